// ---- design/mrp_result_register.sv ----
`timescale 1ns/1ps

// How it works
// - three sections; lower and upper 16 bits
// - lower pins shared with second operand
// - enable low, no preload: drive section
// - enable high, no preload: pins released
// - preload loads sections whose enable high
// - preload captured on rising clock edge
// - preload releases all pins always
// - signed operands: bit 15 negative weight
// - unsigned operands: bit 15 positive weight
// - accumulate adds product to register
// - difference stores product minus register
// - no accumulate: product loaded directly
// - 35-bit precision with sign extension
module mrp_result_register
    import mrp_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire mrp_ctrl_type        ctrl,
    input  wire logic                load_from_pins,
    input  wire logic                guard_drive_enable_n,
    input  wire logic                upper_drive_enable_n,
    input  wire logic                lower_drive_enable_n,
    input  wire logic [LOW_W-1:0]    lower_result_pins_i,
    input  wire logic [UP_W-1:0]     upper_result_pins_i,
    input  wire logic [GUARD_W-1:0]  guard_result_pins_i,
    output logic      [LOW_W-1:0]    lower_result_pins_o,
    output logic      [UP_W-1:0]     upper_result_pins_o,
    output logic      [GUARD_W-1:0]  guard_result_pins_o,
    output logic                     lower_result_pins_oe_n,
    output logic                     upper_result_pins_oe_n,
    output logic                     guard_result_pins_oe_n,
    output logic      [OPND_W-1:0]   second_operand_pins,
    output logic      [ACC_W-1:0]    result_q
);

    // ************************************************
    // pin synchronisers
    // ************************************************
    // pins come from the board, so two flops before the register logic reads them; the pin drive enables use them raw
    logic [ACC_W-1:0] pins_m_q;
    logic [ACC_W-1:0] pins_s_q;
    logic [2:0]       ctl_m_q;
    logic [2:0]       ctl_s_q;
    logic             load_from_pins_m_q;
    logic             load_from_pins_s_q;

    always_ff @(posedge clk) begin
        pins_m_q <= {guard_result_pins_i, upper_result_pins_i, lower_result_pins_i};
        pins_s_q <= pins_m_q;
        ctl_m_q  <= {guard_drive_enable_n, upper_drive_enable_n, lower_drive_enable_n};
        ctl_s_q  <= ctl_m_q;
        load_from_pins_m_q <= load_from_pins;
        load_from_pins_s_q <= load_from_pins_m_q;
    end

    // ************************************************
    // product and accumulate datapath
    // ************************************************
    wire logic               sgn = ctrl.signed_operands;
    wire logic [OPND_W:0]    a_ext = {sgn & ctrl.a_opnd[OPND_SIGN], ctrl.a_opnd};
    wire logic [OPND_W:0]    b_ext = {sgn & ctrl.b_opnd[OPND_SIGN], ctrl.b_opnd};
    wire logic signed [2*OPND_W+1:0] prod_full = $signed(a_ext) * $signed(b_ext);
    wire logic [ACC_W-1:0]   rnd_val = ACC_W'(ctrl.round_enable) << RND_POS;
    // sign extend only in signed mode; unsigned product is zero-filled
    wire logic [ACC_W-1:0]   prod_ext = {{(ACC_W-PROD_W){sgn & prod_full[PROD_W-1]}},
                                         prod_full[PROD_W-1:0]} + rnd_val;
    wire logic [ACC_W-1:0]   sum_val  = prod_ext + result_q;
    wire logic [ACC_W-1:0]   diff_val = prod_ext - result_q;
    wire logic [ACC_W-1:0]   mac_val  = !ctrl.sum_feedback_enable ? prod_ext :
                                        ctrl.difference_enable ? diff_val : sum_val;

    // ************************************************
    // section load select
    // ************************************************
    wire mrp_sect_type       sel = ctl_s_q;
    wire logic [ACC_W-1:0]   pre_mask = {{GUARD_W{sel.guard}}, {UP_W{sel.upper}},
                                         {LOW_W{sel.lower}}};
    // preloading replaces only the enabled sections; others keep their contents
    logic [ACC_W-1:0]        result_d;
    assign result_d = load_from_pins_s_q ? ((pins_s_q & pre_mask) | (result_q & ~pre_mask))
                               : mac_val;

    // no documented reset for the result register; rst only disables the checks
    always_ff @(posedge clk) begin
        result_q <= result_d;
    end

    // ************************************************
    // pin drive
    // ************************************************
    assign lower_result_pins_o    = result_q[LOW_LSB +: LOW_W];
    assign upper_result_pins_o    = result_q[UP_LSB +: UP_W];
    assign guard_result_pins_o    = result_q[GUARD_LSB +: GUARD_W];
    // enables read the raw pins: the drive must follow them combinationally
    assign lower_result_pins_oe_n = load_from_pins | lower_drive_enable_n;
    assign upper_result_pins_oe_n = load_from_pins | upper_drive_enable_n;
    assign guard_result_pins_oe_n = load_from_pins | guard_drive_enable_n;
    assign second_operand_pins    = pins_s_q[LOW_LSB +: LOW_W];

    // ************************************************
    // checks
    // ************************************************
    preload_keep_a: assert property (@(posedge clk) disable iff (rst)
        load_from_pins_s_q && !ctl_s_q[2]
        |=> result_q[SIGN_BIT -: GUARD_W] == $past(result_q[SIGN_BIT -: GUARD_W]))
        else $error("disabled guard section changed on preload");
    preload_take_a: assert property (@(posedge clk) disable iff (rst)
        load_from_pins_s_q && ctl_s_q[0] |=> result_q[LOW_W-1:0] == $past(pins_s_q[LOW_W-1:0]))
        else $error("lower section missed preload");
    pins_release_a: assert property (@(posedge clk) disable iff (rst)
        load_from_pins |-> lower_result_pins_oe_n && upper_result_pins_oe_n
                           && guard_result_pins_oe_n)
        else $error("pins driven during preload");
    lower_drive_a: assert property (@(posedge clk) disable iff (rst)
        !load_from_pins && !lower_drive_enable_n |-> !lower_result_pins_oe_n
                           && lower_result_pins_o == result_q[LOW_W-1:0])
        else $error("lower section not driven");
    load_direct_a: assert property (@(posedge clk) disable iff (rst)
        !load_from_pins_s_q && !ctrl.sum_feedback_enable |=> result_q == $past(prod_ext))
        else $error("product not loaded directly");
    acc_add_a: assert property (@(posedge clk) disable iff (rst)
        !load_from_pins_s_q && ctrl.sum_feedback_enable && !ctrl.difference_enable
        |=> result_q == ACC_W'($past(prod_ext) + $past(result_q)))
        else $error("accumulate sum wrong");
    acc_sub_a: assert property (@(posedge clk) disable iff (rst)
        !load_from_pins_s_q && ctrl.sum_feedback_enable && ctrl.difference_enable
        |=> result_q == ACC_W'($past(prod_ext) - $past(result_q)))
        else $error("difference wrong");
    unsigned_ext_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl.signed_operands |-> prod_full[2*OPND_W+1:PROD_W] == 2'h0)
        else $error("unsigned product has sign bits");
    signed_ext_a: assert property (@(posedge clk) disable iff (rst)
        ctrl.signed_operands && !ctrl.round_enable |-> prod_ext[SIGN_BIT] == prod_ext[PROD_W-1])
        else $error("sign not extended to top bit");

    // ************************************************
    // section and format checks
    // ************************************************

    upper_drive_a: assert property (@(posedge clk) disable iff (rst)
        !load_from_pins && !upper_drive_enable_n |-> !upper_result_pins_oe_n
                           && upper_result_pins_o == result_q[UP_LSB +: UP_W])
        else $error("upper section not driven");

    guard_drive_a: assert property (@(posedge clk) disable iff (rst)
        !load_from_pins && !guard_drive_enable_n |-> !guard_result_pins_oe_n
                           && guard_result_pins_o == result_q[GUARD_LSB +: GUARD_W])
        else $error("guard section not driven");

    lower_release_a: assert property (@(posedge clk) disable iff (rst)
        !load_from_pins && lower_drive_enable_n |-> lower_result_pins_oe_n)
        else $error("lower pins driven while disabled");

    upper_release_a: assert property (@(posedge clk) disable iff (rst)
        !load_from_pins && upper_drive_enable_n |-> upper_result_pins_oe_n)
        else $error("upper pins driven while disabled");

    guard_release_a: assert property (@(posedge clk) disable iff (rst)
        !load_from_pins && guard_drive_enable_n |-> guard_result_pins_oe_n)
        else $error("guard pins driven while disabled");

    upper_take_a: assert property (@(posedge clk) disable iff (rst)
        load_from_pins_s_q && ctl_s_q[1] |=> result_q[UP_LSB +: UP_W] == $past(pins_s_q[UP_LSB +: UP_W]))
        else $error("upper section missed preload");

    guard_take_a: assert property (@(posedge clk) disable iff (rst)
        load_from_pins_s_q && ctl_s_q[2]
        |=> result_q[GUARD_LSB +: GUARD_W] == $past(pins_s_q[GUARD_LSB +: GUARD_W]))
        else $error("guard section missed preload");

    lower_keep_a: assert property (@(posedge clk) disable iff (rst)
        load_from_pins_s_q && !ctl_s_q[0] |=> result_q[LOW_LSB +: LOW_W] == $past(result_q[LOW_LSB +: LOW_W]))
        else $error("disabled lower section changed on preload");

    upper_keep_a: assert property (@(posedge clk) disable iff (rst)
        load_from_pins_s_q && !ctl_s_q[1] |=> result_q[UP_LSB +: UP_W] == $past(result_q[UP_LSB +: UP_W]))
        else $error("disabled upper section changed on preload");

    opnd_delay_a: assert property (@(posedge clk) disable iff (rst)
        second_operand_pins == $past(lower_result_pins_i, 2))
        else $error("operand path does not follow lower pins");

    preload_delay_a: assert property (@(posedge clk) disable iff (rst)
        load_from_pins_s_q == $past(load_from_pins, 2))
        else $error("preload control not synchronised");

    enable_delay_a: assert property (@(posedge clk) disable iff (rst)
        ctl_s_q[0] == $past(lower_drive_enable_n, 2))
        else $error("lower enable not synchronised");

    pins_delay_a: assert property (@(posedge clk) disable iff (rst)
        pins_s_q[GUARD_LSB +: GUARD_W] == $past(guard_result_pins_i, 2))
        else $error("guard pins not synchronised");

    preload_all_a: assert property (@(posedge clk) disable iff (rst)
        load_from_pins_s_q && ctl_s_q == 3'h7 |=> result_q == $past(pins_s_q))
        else $error("full preload overridden by accumulate");

    preload_none_a: assert property (@(posedge clk) disable iff (rst)
        load_from_pins_s_q && ctl_s_q == 3'h0 |=> result_q == $past(result_q))
        else $error("register changed with no section selected");

    signed_fill_a: assert property (@(posedge clk) disable iff (rst)
        ctrl.signed_operands && !ctrl.round_enable
        |-> prod_ext[SIGN_BIT -: GUARD_W] == {GUARD_W{prod_full[PROD_W-1]}})
        else $error("signed product not sign extended");

    unsigned_fill_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl.signed_operands && !ctrl.round_enable |-> prod_ext[SIGN_BIT -: GUARD_W] == 3'h0)
        else $error("unsigned product not zero filled");

    signed_neg_a: assert property (@(posedge clk) disable iff (rst)
        ctrl.signed_operands && ctrl.a_opnd[OPND_SIGN] && !ctrl.b_opnd[OPND_SIGN]
        && ctrl.b_opnd != 16'h0 && !ctrl.round_enable |-> prod_ext[SIGN_BIT])
        else $error("negative operand lost its sign");

    unsigned_big_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl.signed_operands && ctrl.a_opnd[OPND_SIGN] && ctrl.b_opnd != 16'h0
        |-> prod_ext[ACC_W-1:RND_POS] != 20'h0)
        else $error("unsigned top bit lost its weight");

    signed_pos_a: assert property (@(posedge clk) disable iff (rst)
        ctrl.signed_operands && !ctrl.a_opnd[OPND_SIGN] && !ctrl.b_opnd[OPND_SIGN]
        && !ctrl.round_enable |-> !prod_ext[SIGN_BIT])
        else $error("positive product shows sign");

endmodule

// ---- design/mrp_pkg.sv ----
package mrp_pkg;

    // ************************************************
    // widths and field positions
    // ************************************************
    localparam int unsigned LOW_W      = 16;
    localparam int unsigned UP_W       = 16;
    localparam int unsigned GUARD_W    = 3;
    localparam int unsigned ACC_W      = 35;
    localparam int unsigned OPND_W     = 16;
    localparam int unsigned PROD_W     = 32;
    localparam int unsigned LOW_LSB    = 0;
    localparam int unsigned UP_LSB     = 16;
    localparam int unsigned GUARD_LSB  = 32;
    localparam int unsigned SIGN_BIT   = 34;
    localparam int unsigned OPND_SIGN  = 15;
    localparam int unsigned RND_POS    = 15;

    // operand and accumulate controls, already registered by the operand stage
    typedef struct packed {
        logic [OPND_W-1:0] a_opnd;
        logic [OPND_W-1:0] b_opnd;
        logic              signed_operands;
        logic              sum_feedback_enable;
        logic              difference_enable;
        logic              round_enable;
    } mrp_ctrl_type;

    // one bit per section: guard, upper, lower
    typedef struct packed {
        logic guard;
        logic upper;
        logic lower;
    } mrp_sect_type;

endpackage

// ---- verif/mrp_host_model.sv ----
`timescale 1ns/1ps
// host logic sharing the result pins
module mrp_host_model
    import mrp_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             drive,
    input  wire logic [ACC_W-1:0] val,
    input  wire mrp_sect_type     dev_oe_n,
    input  wire logic [ACC_W-1:0] dev_val,
    output logic      [ACC_W-1:0] pin_lvl
);
    logic [ACC_W-1:0] dev_m;
    logic [ACC_W-1:0] last_q = '0;
    assign dev_m = {{GUARD_W{!dev_oe_n.guard}}, {UP_W{!dev_oe_n.upper}},
                    {LOW_W{!dev_oe_n.lower}}};
    // host drives only once the device has let go of every section
    assign pin_lvl = (drive && &dev_oe_n) ? val
                                          : (dev_val & dev_m) | (~last_q & ~dev_m);
    // a floating pin toggles every cycle so a stale value never passes
    always @(posedge clk) last_q <= pin_lvl;
endmodule

// ---- verif/mac_result_register_preload_tb_top.sv ----
`timescale 1ns/1ps
module mac_result_register_preload_tb_top;
    import mrp_pkg::*;
    logic             clk = 0, rst = 1, load = 0, hd = 0;
    mrp_ctrl_type     c = '0;
    mrp_sect_type     en_n = '1, oe_n;
    logic [ACC_W-1:0] hv = '0, pins, dout, res, e, m;
    logic [15:0]      bop, s = 16'h0043;
    int               bad_count = 0, compares = 0;
    always #50 clk = ~clk;
    mrp_result_register mrp_result_register_inst (.clk(clk), .rst(rst), .ctrl(c),
        .load_from_pins(load), .guard_drive_enable_n(en_n.guard),
        .upper_drive_enable_n(en_n.upper), .lower_drive_enable_n(en_n.lower),
        .lower_result_pins_i(pins[15:0]), .upper_result_pins_i(pins[31:16]),
        .guard_result_pins_i(pins[34:32]), .lower_result_pins_o(dout[15:0]),
        .upper_result_pins_o(dout[31:16]), .guard_result_pins_o(dout[34:32]),
        .lower_result_pins_oe_n(oe_n.lower), .upper_result_pins_oe_n(oe_n.upper),
        .guard_result_pins_oe_n(oe_n.guard), .second_operand_pins(bop), .result_q(res));
    mrp_host_model mrp_host_model_inst (.clk(clk), .drive(hd), .val(hv), .dev_oe_n(oe_n),
        .dev_val(dout), .pin_lvl(pins));
    function automatic logic [15:0] lfsr(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [ACC_W-1:0] mac_exp(mrp_ctrl_type k, logic [ACC_W-1:0] p);
        logic [ACC_W-1:0] x, y;
        x = {{19{k.signed_operands & k.a_opnd[15]}}, k.a_opnd};
        y = {{19{k.signed_operands & k.b_opnd[15]}}, k.b_opnd};
        x = x * y + {k.round_enable, 15'h0000};
        return !k.sum_feedback_enable ? x : k.difference_enable ? x - p : x + p;
    endfunction
    task automatic chk(string n, logic [ACC_W-1:0] x, logic [ACC_W-1:0] g);
        compares++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    task tick;
        @(posedge clk);
        #10;
    endtask
    task test_done;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        test_done;
    end
    initial begin
        repeat (10) @(posedge clk);
        #10 rst = 0;
        for (int i = 0; i < 40; i++) begin
            s = lfsr(s);
            c.a_opnd = i < 3 ? 16'h8000 : s;
            s = lfsr(s);
            c.b_opnd = i < 2 ? 16'h8000 : i < 4 ? 16'hffff : s;
            {c.signed_operands, c.sum_feedback_enable, c.difference_enable, c.round_enable} = s[3:0];
            if (i == 0) c.sum_feedback_enable = 0;
            en_n = s[6:4];
            #1 chk("oe_n", {32'h0, en_n}, {32'h0, oe_n});
            if (i > 0) chk("pins_o", e, dout);
            e = mac_exp(c, e);
            tick;
            chk("result", e, res);
        end
        $display("mac test done");
        c = '0;
        c.sum_feedback_enable = 1;
        for (int i = 0; i < 8; i++) begin
            s = lfsr(s);
            en_n = s[2:0];
            hv[15:0] = s;
            s = lfsr(s);
            hv[34:16] = {s[2:0], s};
            load = 1;
            hd = 1;
            #1 chk("oe_n_pre", 35'h7, {32'h0, oe_n});
            repeat (4) tick;
            m = {{3{en_n.guard}}, {16{en_n.upper}}, {16{en_n.lower}}};
            e = (hv & m) | (e & ~m);
            chk("preload", e, res);
            chk("opnd_b", {19'h0, hv[15:0]}, {19'h0, bop});
            hd = 0;
            load = 0;
            repeat (3) tick;
            c.a_opnd = s;
            c.b_opnd = ~s;
            c.difference_enable = s[0];
            e = mac_exp(c, e);
            tick;
            chk("accum", e, res);
            c = '0;
            c.sum_feedback_enable = 1;
        end
        $display("preload test done");
        test_done;
    end
endmodule
